// ==== logic/pbc_defines.vh ====
// Purpose: constants for the power bus command core
// Assumes: 25 MHz clock
// Notes:   command codes, reset values, field positions and timing counts
`ifndef PBC_DEFINES_VH
`define PBC_DEFINES_VH

// ****************************************
// command codes
// ****************************************
`define PBC_CMD_PAGE            8'h00
`define PBC_CMD_ON_OFF          8'h01
`define PBC_CMD_START_CFG       8'h02
`define PBC_CMD_CLEAR_FAULTS    8'h03
`define PBC_CMD_STORE_DEFAULT   8'h11
`define PBC_CMD_RESTORE_DEFAULT 8'h12
`define PBC_CMD_STORE_USER      8'h15
`define PBC_CMD_RESTORE_USER    8'h16
`define PBC_CMD_VOUT_MODE       8'h20
`define PBC_CMD_VOUT_TARGET     8'h21
`define PBC_CMD_VOUT_TRIM       8'h22
`define PBC_CMD_SECURITY        8'hFA
`define PBC_CMD_FACTORY_RELOAD  8'hF4

// ****************************************
// reset values and codes
// ****************************************
`define PBC_PAGE_RST            8'h00
`define PBC_ON_OFF_RST          8'h00
`define PBC_START_CFG_RST       8'h17
`define PBC_PAGE_CTRL0          8'h00
`define PBC_PAGE_CTRL1          8'h01
`define PBC_PAGE_BOTH           8'hFF
`define PBC_VOUT_MODE_VAL       8'h13
`define PBC_SECURITY_AFTER_LOAD 8'h01

// ****************************************
// field positions
// ****************************************
`define PBC_STATE_HI            7
`define PBC_STATE_LO            6
`define PBC_MARGIN_HI           5
`define PBC_MARGIN_LO           4
`define PBC_SRC_HI              4
`define PBC_SRC_LO              2
`define PBC_POL_BIT             1
`define PBC_FAST_OFF_BIT        0
`define PBC_ST_IMM_OFF          2'h0
`define PBC_ST_SOFT_OFF         2'h1
`define PBC_ST_ON               2'h2
`define PBC_MG_NOM              2'h0
`define PBC_MG_LOW              2'h1
`define PBC_MG_HIGH             2'h2
`define PBC_SRC_PIN             3'h5
`define PBC_SRC_CMD             3'h6

// ****************************************
// timing
// ****************************************
`define PBC_CLK_HZ              25000000
`define PBC_NVM_BUSY_MS         100
`define PBC_NVM_BUSY_CYC        ((`PBC_CLK_HZ / 1000) * `PBC_NVM_BUSY_MS)

`endif

// ==== logic/pbc_nvm_timer.v ====
// Purpose: busy window counter for nonvolatile store and restore
// Assumes: start is a one-cycle pulse
// Notes:   busy rises the cycle after start, holds for CYCLES cycles
`timescale 1ns/10ps

module pbc_nvm_timer #(
    parameter CYCLES = 2500000
) (
    // clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // control
    input  wire        start,
    output reg         busy_reg,
    output reg         done_reg
);
    reg  [31:0] count_reg;

    always @(posedge clk) begin
        if (!rst_n) begin
            count_reg <= 32'h0;
            busy_reg  <= 1'b0;
            done_reg  <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (start && !busy_reg) begin
                count_reg <= CYCLES - 1;
                busy_reg  <= 1'b1;
            end else if (busy_reg) begin
                if (count_reg == 32'h0) begin
                    busy_reg <= 1'b0;
                    done_reg <= 1'b1;
                end else begin
                    count_reg <= count_reg - 32'h1;
                end
            end
        end
    end
endmodule // pbc_nvm_timer

// ==== logic/pbc_core.v ====
// Purpose: command handling core of a two-controller step-down converter
// Assumes: a bus front end delivers decoded command transactions synchronous to clk
// Notes:   one transaction per cmd_valid pulse; answers one cycle later
`timescale 1ns/10ps
`include "pbc_defines.vh"

module pbc_core #(
    parameter NVM_BUSY_CYC = `PBC_NVM_BUSY_CYC,
    parameter NFAULT       = 8
) (
    // clock and reset
    input  wire              clk,
    input  wire              rst_n,
    // command transaction from the bus front end
    input  wire              cmd_valid,
    input  wire              cmd_write,
    input  wire [7:0]        cmd_code,
    input  wire [1:0]        cmd_len,
    input  wire [15:0]       cmd_wdata,
    // answer to the bus front end
    output reg               rsp_valid,
    output reg               rsp_ack,
    output reg  [15:0]       rsp_rdata,
    output reg               cmd_error,
    output reg               nvm_busy,
    // controller enable pins, active high
    input  wire [1:0]        en_pin,
    // fault conditions per controller
    input  wire [NFAULT-1:0] fault_cond0,
    input  wire [NFAULT-1:0] fault_cond1,
    output reg  [NFAULT-1:0] fault_status0,
    output reg  [NFAULT-1:0] fault_status1,
    output reg               alert_output_pin,
    // power stage control per controller
    output reg  [1:0]        out_enable,
    output reg  [1:0]        out_fast_off,
    output reg  [3:0]        margin_sel,
    output reg  [31:0]       vout_target_applied,
    output reg  [31:0]       vout_trim_applied,
    // nonvolatile store port
    output reg               nvm_store_default,
    output reg               nvm_store_user,
    output reg               nvm_restore_default,
    output reg               nvm_restore_user,
    output reg  [7:0]        security_level
);
    // ****************************************
    // operating memory
    // ****************************************
    reg  [7:0]  page_select_reg;
    reg  [7:0]  output_on_off_margin_reg [0:1];
    reg  [7:0]  start_source_config_reg [0:1];
    reg  [15:0] vout_target_reg [0:1];
    reg  [15:0] vout_trim_reg [0:1];
    reg  [7:0]  default_store_cfg_reg [0:1];
    reg  [7:0]  user_store_cfg_reg [0:1];
    reg  [1:0]  on_reg;
    reg  [1:0]  en_pin_q_reg;
    reg  [1:0]  pending_restore_reg;
    wire        timer_busy;
    wire        timer_done;
    wire        nvm_start;
    integer     i;
    integer     j;

    // ****************************************
    // decode helpers
    // ****************************************
    function page_hits;
        input [7:0] page;
        input       ctrl;
        begin
            page_hits = (page == `PBC_PAGE_BOTH) ||
                        (page == `PBC_PAGE_CTRL0 && !ctrl) ||
                        (page == `PBC_PAGE_CTRL1 && ctrl);
        end
    endfunction

    function on_off_legal;
        input [7:0] v;
        begin
            // state 11 is not one of the five codes, whatever the margin
            on_off_legal = (v[3:0] == 4'h0) &&
                (((v[7:6] == `PBC_ST_IMM_OFF || v[7:6] == `PBC_ST_SOFT_OFF) &&
                  v[5:4] == `PBC_MG_NOM) ||
                 (v[7:6] == `PBC_ST_ON && v[5:4] != 2'h3));
        end
    endfunction

    // refusal follows the busy output so the host never sees an ack it was told to expect not
    wire        wr_take   = cmd_valid && cmd_write && !nvm_busy;
    wire        page_sel1 = (page_select_reg == `PBC_PAGE_CTRL1);
    wire        nvm_cmd   = (cmd_code == `PBC_CMD_STORE_DEFAULT) || (cmd_code == `PBC_CMD_RESTORE_DEFAULT) ||
                            (cmd_code == `PBC_CMD_STORE_USER) || (cmd_code == `PBC_CMD_RESTORE_USER);
    assign nvm_start = wr_take && nvm_cmd && (cmd_len == 2'h0);

    // ****************************************
    // nonvolatile busy window
    // ****************************************
    pbc_nvm_timer #(
        .CYCLES (NVM_BUSY_CYC)
    ) u_timer (
        .clk      (clk),
        .rst_n    (rst_n),
        .start    (nvm_start),
        .busy_reg (timer_busy),
        .done_reg (timer_done)
    );

    // ****************************************
    // bus answer
    // ****************************************
    always @(posedge clk) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
            rsp_ack   <= 1'b0;
            rsp_rdata <= 16'h0000;
            cmd_error <= 1'b0;
        end else begin
            rsp_valid <= cmd_valid;
            rsp_ack   <= cmd_valid && !nvm_busy;
            cmd_error <= wr_take && cmd_code == `PBC_CMD_ON_OFF && !on_off_legal(cmd_wdata[7:0]);
            rsp_rdata <= 16'h0000;
            if (cmd_valid && !cmd_write && !nvm_busy) begin
                // only the on/off read depends on output state, through its state field
                case (cmd_code)
                    `PBC_CMD_PAGE:        rsp_rdata <= {8'h00, page_select_reg};
                    // live state, not the last value written
                    `PBC_CMD_ON_OFF:      rsp_rdata <= {8'h00, on_reg[page_sel1] ? `PBC_ST_ON : `PBC_ST_IMM_OFF,
                                                        output_on_off_margin_reg[page_sel1][5:0]};
                    `PBC_CMD_START_CFG:   rsp_rdata <= {8'h00, start_source_config_reg[page_sel1]};
                    `PBC_CMD_VOUT_MODE:   rsp_rdata <= {8'h00, `PBC_VOUT_MODE_VAL};
                    `PBC_CMD_VOUT_TARGET: rsp_rdata <= vout_target_reg[page_sel1];
                    `PBC_CMD_VOUT_TRIM:   rsp_rdata <= vout_trim_reg[page_sel1];
                    `PBC_CMD_SECURITY:    rsp_rdata <= {8'h00, security_level};
                    default:              rsp_rdata <= 16'h0000;
                endcase
            end
        end
    end

    // ****************************************
    // command writes and nonvolatile copies
    // ****************************************
    always @(posedge clk) begin
        if (!rst_n) begin
            page_select_reg     <= `PBC_PAGE_RST;
            security_level      <= `PBC_SECURITY_AFTER_LOAD;
            nvm_busy            <= 1'b0;
            nvm_store_default   <= 1'b0;
            nvm_store_user      <= 1'b0;
            nvm_restore_default <= 1'b0;
            nvm_restore_user    <= 1'b0;
            pending_restore_reg <= 2'h0;
            for (i = 0; i < 2; i = i + 1) begin
                output_on_off_margin_reg[i] <= `PBC_ON_OFF_RST;
                start_source_config_reg[i]  <= `PBC_START_CFG_RST;
                default_store_cfg_reg[i]    <= `PBC_START_CFG_RST;
                user_store_cfg_reg[i]       <= `PBC_START_CFG_RST;
                vout_target_reg[i]          <= 16'h0000;
                vout_trim_reg[i]            <= 16'h0000;
            end
        end else begin
            nvm_busy            <= timer_busy || nvm_start;
            nvm_store_default   <= nvm_start && cmd_code == `PBC_CMD_STORE_DEFAULT;
            nvm_store_user      <= nvm_start && cmd_code == `PBC_CMD_STORE_USER;
            nvm_restore_default <= nvm_start && cmd_code == `PBC_CMD_RESTORE_DEFAULT;
            nvm_restore_user    <= nvm_start && cmd_code == `PBC_CMD_RESTORE_USER;
            if (nvm_start) begin
                case (cmd_code)
                    `PBC_CMD_STORE_DEFAULT: begin
                        for (i = 0; i < 2; i = i + 1)
                            default_store_cfg_reg[i] <= start_source_config_reg[i];
                    end
                    `PBC_CMD_STORE_USER: begin
                        for (i = 0; i < 2; i = i + 1)
                            user_store_cfg_reg[i] <= start_source_config_reg[i];
                    end
                    `PBC_CMD_RESTORE_DEFAULT: pending_restore_reg <= 2'h1;
                    `PBC_CMD_RESTORE_USER:    pending_restore_reg <= 2'h2;
                    default:                  pending_restore_reg <= 2'h0;
                endcase
            end
            // restore lands at the end of the window so settings never change mid-copy
            if (timer_done && pending_restore_reg != 2'h0) begin
                for (i = 0; i < 2; i = i + 1)
                    start_source_config_reg[i] <= (pending_restore_reg == 2'h1) ?
                        default_store_cfg_reg[i] : user_store_cfg_reg[i];
                security_level      <= `PBC_SECURITY_AFTER_LOAD;
                pending_restore_reg <= 2'h0;
            end
            if (wr_take && !nvm_cmd) begin
                if (cmd_code == `PBC_CMD_PAGE && cmd_len == 2'h1)
                    page_select_reg <= cmd_wdata[7:0];
                for (i = 0; i < 2; i = i + 1) begin
                    if (page_hits(page_select_reg, i[0]) && cmd_len != 2'h0) begin
                        if (cmd_code == `PBC_CMD_ON_OFF && on_off_legal(cmd_wdata[7:0]))
                            output_on_off_margin_reg[i] <= cmd_wdata[7:0];
                        if (cmd_code == `PBC_CMD_START_CFG)
                            start_source_config_reg[i] <= {3'h0, cmd_wdata[4:2], 1'b1, cmd_wdata[0]};
                        if (cmd_code == `PBC_CMD_VOUT_TARGET)
                            vout_target_reg[i] <= cmd_wdata;
                        if (cmd_code == `PBC_CMD_VOUT_TRIM)
                            vout_trim_reg[i] <= cmd_wdata;
                    end
                end
            end
        end
    end

    // ****************************************
    // output control per controller
    // ****************************************
    always @(posedge clk) begin
        if (!rst_n) begin
            on_reg              <= 2'h0;
            en_pin_q_reg        <= 2'h0;
            out_enable          <= 2'h0;
            out_fast_off        <= 2'h0;
            margin_sel          <= 4'h0;
            vout_target_applied <= 32'h0;
            vout_trim_applied   <= 32'h0;
        end else begin
            en_pin_q_reg <= en_pin;
            for (j = 0; j < 2; j = j + 1) begin
                if (start_source_config_reg[j][`PBC_SRC_HI:`PBC_SRC_LO] == `PBC_SRC_PIN) begin
                    on_reg[j] <= en_pin[j];
                    if (en_pin_q_reg[j] && !en_pin[j])
                        out_fast_off[j] <= start_source_config_reg[j][`PBC_FAST_OFF_BIT];
                end else begin
                    on_reg[j] <= (output_on_off_margin_reg[j][`PBC_STATE_HI:`PBC_STATE_LO] == `PBC_ST_ON);
                    if (output_on_off_margin_reg[j][`PBC_STATE_HI:`PBC_STATE_LO] == `PBC_ST_IMM_OFF)
                        out_fast_off[j] <= 1'b1;
                    else if (output_on_off_margin_reg[j][`PBC_STATE_HI:`PBC_STATE_LO] == `PBC_ST_SOFT_OFF)
                        out_fast_off[j] <= 1'b0;
                end
                out_enable[j]       <= on_reg[j];
                margin_sel[2*j +: 2] <= on_reg[j] ? output_on_off_margin_reg[j][`PBC_MARGIN_HI:`PBC_MARGIN_LO]
                                                 : `PBC_MG_NOM;
                // target and trim follow the registers while off and hold while on
                if (!on_reg[j]) begin
                    vout_target_applied[16*j +: 16] <= vout_target_reg[j];
                    vout_trim_applied[16*j +: 16]   <= vout_trim_reg[j];
                end
            end
        end
    end

    // ****************************************
    // faults and alert
    // ****************************************
    wire clear_faults = wr_take && cmd_code == `PBC_CMD_CLEAR_FAULTS && cmd_len == 2'h0;

    always @(posedge clk) begin
        if (!rst_n) begin
            fault_status0    <= {NFAULT{1'b0}};
            fault_status1    <= {NFAULT{1'b0}};
            alert_output_pin <= 1'b0;
        end else begin
            // live conditions win over the clear; output state is untouched
            fault_status0    <= (clear_faults ? {NFAULT{1'b0}} : fault_status0) | fault_cond0;
            fault_status1    <= (clear_faults ? {NFAULT{1'b0}} : fault_status1) | fault_cond1;
            alert_output_pin <= clear_faults ? (|fault_cond0 || |fault_cond1)
                                             : (alert_output_pin || |fault_cond0 || |fault_cond1);
        end
    end
endmodule // pbc_core

// ==== testbench/pbc_host_model.sv ====
// Purpose: host controller model that issues command transactions to the core
// Assumes: core answers one cycle after the request edge
// Notes:   idle code and data lines carry the inverse of the last value so nothing stale passes
`timescale 1ns/10ps

module pbc_host_model (
    // clock
    input  wire        clk,
    // request side
    output reg         cmd_valid,
    output reg         cmd_write,
    output reg  [7:0]  cmd_code,
    output reg  [1:0]  cmd_len,
    output reg  [15:0] cmd_wdata,
    // answer side
    input  wire        rsp_valid,
    input  wire        rsp_ack,
    input  wire [15:0] rsp_rdata,
    input  wire        cmd_error
);
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code  = 8'hAA;
        cmd_len   = 2'h0;
        cmd_wdata = 16'h5555;
    end

    // one request; answer is taken at the edge after the request edge
    // pacing gaps are shortened, the core accepts back to back
    task xfer(input w, input [7:0] c, input [1:0] l, input [15:0] d,
              output a, output [15:0] q, output e);
        begin
            @(posedge clk);
            #1;
            cmd_valid = 1'b1;
            cmd_write = w;
            cmd_code  = c;
            cmd_len   = l;
            cmd_wdata = d;
            @(posedge clk);
            #1;
            cmd_valid = 1'b0;
            cmd_code  = ~c;
            cmd_wdata = ~d;
            a = rsp_valid & rsp_ack;
            q = rsp_rdata;
            e = cmd_error;
        end
    endtask
endmodule // pbc_host_model

// ==== testbench/pbc_core_sva.sv ====
// Purpose: port-level assertions for the command core
// Assumes: single clock, synchronous active-low reset
// Notes:   attached by bind at the foot of this file
`timescale 1ns/10ps

module pbc_core_sva #(
    parameter NFAULT = 8
) (
    input wire              clk,
    input wire              rst_n,
    input wire              cmd_valid,
    input wire              cmd_write,
    input wire [7:0]        cmd_code,
    input wire [15:0]       cmd_wdata,
    input wire              rsp_valid,
    input wire              rsp_ack,
    input wire [15:0]       rsp_rdata,
    input wire              cmd_error,
    input wire              nvm_busy,
    input wire              nvm_store_default,
    input wire [NFAULT-1:0] fault_cond0,
    input wire [NFAULT-1:0] fault_status0,
    input wire [7:0]        security_level
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_rsp_follows_cmd: assert property (cmd_valid |=> rsp_valid)
        else $error("no answer after request");
    a_rsp_not_idle: assert property (!cmd_valid |=> !rsp_valid)
        else $error("answer without request");
    a_busy_refuses: assert property (cmd_valid && nvm_busy |=> rsp_valid && !rsp_ack)
        else $error("request taken while busy");
    a_idle_accepts: assert property (cmd_valid && !nvm_busy |=> rsp_ack)
        else $error("request refused while idle");
    a_store_starts: assert property (cmd_valid && cmd_write && cmd_code == 8'h11 && !nvm_busy
        |=> nvm_store_default ##[0:1] nvm_busy)
        else $error("store did not start busy window");
    a_illegal_flags: assert property (cmd_valid && cmd_write && cmd_code == 8'h01 && !nvm_busy
        && cmd_wdata[7:0] == 8'hC0 |=> cmd_error)
        else $error("illegal code not flagged");
    a_error_cause: assert property (cmd_error |-> $past(cmd_valid && cmd_write && cmd_code == 8'h01))
        else $error("error without on/off write");
    a_write_rdata: assert property (rsp_valid && $past(cmd_write) |-> rsp_rdata == 16'h0000)
        else $error("write answer carries data");
    a_fault_latch: assert property (fault_cond0[0] ##1 fault_cond0[0] |-> fault_status0[0])
        else $error("live fault not latched");
    a_security_rst: assert property ($past(!rst_n) |-> security_level == 8'h01)
        else $error("security level not public after reset");
endmodule // pbc_core_sva

bind pbc_core pbc_core_sva #(.NFAULT(NFAULT)) pbc_core_sva_i (
    .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_ack(rsp_ack), .rsp_rdata(rsp_rdata),
    .cmd_error(cmd_error), .nvm_busy(nvm_busy), .nvm_store_default(nvm_store_default),
    .fault_cond0(fault_cond0), .fault_status0(fault_status0), .security_level(security_level));

// ==== testbench/power_bus_command_core_tb.sv ====
// Purpose: self-checking bench for the command core
// Assumes: store/restore window shortened to 20 cycles
// Notes:   random data from a fixed-seed shift register
`timescale 1ns/10ps

module power_bus_command_core_tb;
    reg         clk;
    reg         rst_n;
    reg  [1:0]  en_pin;
    reg  [7:0]  fault_cond0;
    reg  [7:0]  fault_cond1;
    wire        cmd_valid, cmd_write, rsp_valid, rsp_ack, cmd_error, nvm_busy, alert_output_pin;
    wire [7:0]  cmd_code, fault_status0, fault_status1, security_level;
    wire [1:0]  cmd_len, out_enable, out_fast_off;
    wire [15:0] cmd_wdata, rsp_rdata;
    wire [3:0]  margin_sel;
    integer     mismatches, comparisons, i;
    reg  [31:0] seed;
    reg  [15:0] q;
    reg         a, e;
    reg  [7:0]  v;

    pbc_core #(.NVM_BUSY_CYC(20)) pbc_core_i (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_len(cmd_len), .cmd_wdata(cmd_wdata),
        .rsp_valid(rsp_valid), .rsp_ack(rsp_ack), .rsp_rdata(rsp_rdata), .cmd_error(cmd_error),
        .nvm_busy(nvm_busy), .en_pin(en_pin), .fault_cond0(fault_cond0), .fault_cond1(fault_cond1),
        .fault_status0(fault_status0), .fault_status1(fault_status1), .alert_output_pin(alert_output_pin),
        .out_enable(out_enable), .out_fast_off(out_fast_off), .margin_sel(margin_sel),
        .vout_target_applied(), .vout_trim_applied(), .nvm_store_default(), .nvm_store_user(),
        .nvm_restore_default(), .nvm_restore_user(), .security_level(security_level));
    pbc_host_model pbc_host_model_i (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_len(cmd_len), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
        .rsp_ack(rsp_ack), .rsp_rdata(rsp_rdata), .cmd_error(cmd_error));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    function [31:0] lfsr(input [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // config readback: unused bits forced low, polarity bit forced high
    function [15:0] cfg_exp(input [7:0] w);
        cfg_exp = {8'h00, (w & 8'h1F) | 8'h02};
    endfunction

    task chk(input [8*12-1:0] name, input [15:0] exp, input [15:0] got);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("[FAIL] %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task wr(input [7:0] c, input [1:0] l, input [15:0] d, input ok);
        begin
            pbc_host_model_i.xfer(1'b1, c, l, d, a, q, e);
            chk("write ack", {15'h0, ok}, {15'h0, a});
        end
    endtask
    task rd(input [7:0] c, input [15:0] exp);
        begin
            pbc_host_model_i.xfer(1'b0, c, 2'h1, 16'h0000, a, q, e);
            chk("read ack", 16'h0001, {15'h0, a});
            chk("read data", exp, q);
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task wait_idle;
        begin
            i = 0;
            while (nvm_busy !== 1'b0 && i < 60) begin
                tick(1);
                i = i + 1;
            end
            chk("busy ends", 16'h0000, {15'h0, nvm_busy});
        end
    endtask
    task close_out;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, mismatches);
            if (mismatches == 0 && comparisons > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask

    initial begin
        #2000000;
        mismatches = mismatches + 1;
        close_out;
    end

    initial begin
        mismatches = 0;
        comparisons = 0;
        seed = 32'h4E6F;
        rst_n = 1'b0;
        en_pin = 2'h0;
        fault_cond0 = 8'h00;
        fault_cond1 = 8'h00;
        tick(2);
        rst_n = 1'b1;
        rd(8'h00, 16'h0000);
        rd(8'h01, 16'h0000);
        rd(8'h02, 16'h0017);
        $display("test reset values done");
        // pin source with fast and soft turn-off
        en_pin = 2'h1;
        tick(4);
        chk("pin on", 16'h0001, {14'h0, out_enable});
        en_pin = 2'h0;
        tick(4);
        chk("pin off", 16'h0000, {14'h0, out_enable});
        chk("fast off", 16'h0001, {15'h0, out_fast_off[0]});
        wr(8'h02, 2'h1, 16'h0014, 1'b1);
        en_pin = 2'h1;
        tick(4);
        en_pin = 2'h0;
        tick(4);
        chk("soft off", 16'h0000, {15'h0, out_fast_off[0]});
        for (i = 0; i < 4; i = i + 1) begin
            seed = lfsr(seed);
            v = seed[7:0];
            wr(8'h02, 2'h1, {8'h00, v}, 1'b1);
            rd(8'h02, cfg_exp(v));
        end
        wr(8'h00, 2'h1, 16'h00FF, 1'b1);
        wr(8'h02, 2'h1, 16'h001B, 1'b1);
        $display("test start source done");
        // page routing and the five state codes
        wr(8'h00, 2'h1, 16'h0000, 1'b1);
        wr(8'h01, 2'h1, 16'h0080, 1'b1);
        tick(4);
        chk("page0 on", 16'h0001, {14'h0, out_enable});
        wr(8'h00, 2'h1, 16'h0001, 1'b1);
        rd(8'h00, 16'h0001);
        wr(8'h01, 2'h1, 16'h0080, 1'b1);
        tick(4);
        chk("page1 on", 16'h0003, {14'h0, out_enable});
        wr(8'h00, 2'h1, 16'h00FF, 1'b1);
        for (i = 0; i < 3; i = i + 1) begin
            wr(8'h01, 2'h1, 16'h0080 | (i << 4), 1'b1);
            tick(4);
            chk("margin", {12'h0, i[1:0], i[1:0]}, {12'h0, margin_sel});
            rd(8'h01, 16'h0080 | (i << 4));
        end
        wr(8'h01, 2'h1, 16'h00C0, 1'b1);
        chk("cmd error", 16'h0001, {15'h0, e});
        rd(8'h01, 16'h00A0);
        wr(8'h01, 2'h1, 16'h0040, 1'b1);
        tick(4);
        chk("soft cmd off", 16'h0000, {14'h0, out_enable});
        rd(8'h01, 16'h0000);
        wr(8'h01, 2'h1, 16'h0080, 1'b1);
        wr(8'h01, 2'h1, 16'h0000, 1'b1);
        tick(2);
        chk("imm off", 16'h0000, {14'h0, out_enable});
        chk("imm fast", 16'h0003, {14'h0, out_fast_off});
        $display("test paging done");
        // fault latch and clear, one condition persisting
        seed = lfsr(seed);
        fault_cond0 = seed[7:0] | 8'h01;
        fault_cond1 = 8'h04;
        tick(3);
        chk("fault0", {8'h00, fault_cond0}, {8'h00, fault_status0});
        fault_cond0 = 8'h00;
        wr(8'h03, 2'h0, 16'h0000, 1'b1);
        tick(2);
        chk("cleared0", 16'h0000, {8'h00, fault_status0});
        chk("persist1", 16'h0004, {8'h00, fault_status1});
        chk("no restart", 16'h0000, {14'h0, out_enable});
        fault_cond1 = 8'h00;
        wr(8'h03, 2'h0, 16'h0000, 1'b1);
        tick(2);
        chk("cleared1", 16'h0000, {8'h00, fault_status1});
        chk("alert off", 16'h0000, {15'h0, alert_output_pin});
        $display("test faults done");
        // store, a refused write while busy, restores
        wr(8'h11, 2'h0, 16'h0000, 1'b1);
        chk("busy", 16'h0001, {15'h0, nvm_busy});
        wr(8'h02, 2'h1, 16'h0017, 1'b0);
        wait_idle;
        rd(8'h02, 16'h001B);
        wr(8'h02, 2'h1, 16'h0017, 1'b1);
        wr(8'h12, 2'h0, 16'h0000, 1'b1);
        wait_idle;
        tick(2);
        rd(8'h02, 16'h001B);
        chk("security", 16'h0001, {8'h00, security_level});
        wr(8'h16, 2'h0, 16'h0000, 1'b1);
        chk("user busy", 16'h0001, {15'h0, nvm_busy});
        wait_idle;
        chk("security u", 16'h0001, {8'h00, security_level});
        rd(8'h02, 16'h0017);
        wr(8'h15, 2'h0, 16'h0000, 1'b1);
        wait_idle;
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        rd(8'h00, 16'h0000);
        $display("test store restore done");
        close_out;
    end
endmodule // power_bus_command_core_tb
